/* File: core/ddsk_core.sv */
module ddsk_core
    import ddsk_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic key_pin,
    input wire logic update_pin,
    output logic quarter_rate_clock,
    output ddsk_out_type dds_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic key_s1, key_s2, key_s3;
    logic upd_s1, upd_s2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_s1 <= 1'b0;
            key_s2 <= 1'b0;
            key_s3 <= 1'b0;
            upd_s1 <= 1'b0;
            upd_s2 <= 1'b0;
        end else if (ce) begin
            key_s1 <= key_pin;
            key_s2 <= key_s1;
            key_s3 <= key_s2;
            upd_s1 <= update_pin;
            upd_s2 <= upd_s1;
        end
    end
    // ----------------------------------------
    // Quarter-rate clock and update capture
    // ----------------------------------------
    logic [1:0] div;
    logic upd_prev;
    logic sw_update;
    logic update;
    logic quarter_edge;
    assign quarter_edge = (div == QUARTER_DIV);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= '0;
            quarter_rate_clock <= 1'b0;
            upd_prev <= 1'b0;
        end else if (ce) begin
            div <= div + 1'b1;
            quarter_rate_clock <= div[1];
            if (quarter_edge) begin
                upd_prev <= upd_s2;
            end
        end
    end
    assign update = ce && ((quarter_edge && upd_s2 && !upd_prev) || sw_update);
    // ----------------------------------------
    // Register bus: shadow and active sets
    // ----------------------------------------
    ddsk_regs_type shadow;
    ddsk_regs_type active;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] merged;
    logic [31:0] old_word;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_comb begin
        old_word = '0;
        if (aw_addr == ADDR_CONTROL) begin
            old_word = shadow.control;
        end else if (aw_addr == ADDR_SCALE) begin
            old_word = {16'h0000, shadow.scale};
        end else if (aw_addr == ADDR_RAMP) begin
            old_word = {24'h00_0000, shadow.ramp_rate};
        end else if (aw_addr == ADDR_TUNING) begin
            old_word = shadow.tuning;
        end else if (aw_addr == ADDR_PHASE) begin
            old_word = {22'h00_0000, shadow.phase};
        end
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : old_word[i*8 +: 8];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr <= ADDR_UPDATE && aw_addr[1:0] == 2'b00) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow <= '0;
            shadow.control <= CONTROL_RESET;
            sw_update <= 1'b0;
        end else if (ce) begin
            sw_update <= 1'b0;
            if (do_write) begin
                if (aw_addr == ADDR_CONTROL) begin
                    shadow.control <= merged & CONTROL_WRITE_MASK;
                end else if (aw_addr == ADDR_SCALE) begin
                    shadow.scale <= merged[15:0];
                end else if (aw_addr == ADDR_RAMP) begin
                    shadow.ramp_rate <= merged[7:0];
                end else if (aw_addr == ADDR_TUNING) begin
                    shadow.tuning <= merged;
                end else if (aw_addr == ADDR_PHASE) begin
                    shadow.phase <= merged[PHASE_OFF_W-1:0];
                end else if (aw_addr == ADDR_UPDATE) begin
                    sw_update <= merged[0];
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active <= '0;
            active.control <= CONTROL_RESET;
        end else if (update) begin
            active <= shadow;
        end
    end
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    logic [SCALE_W-1:0] ramp_count;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                if (s_axi_araddr == ADDR_CONTROL) begin
                    s_axi_rdata <= shadow.control;
                end else if (s_axi_araddr == ADDR_SCALE) begin
                    s_axi_rdata <= {16'h0000, shadow.scale};
                end else if (s_axi_araddr == ADDR_RAMP) begin
                    s_axi_rdata <= {24'h00_0000, shadow.ramp_rate};
                end else if (s_axi_araddr == ADDR_TUNING) begin
                    s_axi_rdata <= shadow.tuning;
                end else if (s_axi_araddr == ADDR_PHASE) begin
                    s_axi_rdata <= {22'h00_0000, shadow.phase};
                end else if (s_axi_araddr == ADDR_UPDATE) begin
                    s_axi_rdata <= '0;
                end else if (s_axi_araddr == ADDR_STATUS) begin
                    s_axi_rdata <= {16'h0000, key_s2, 1'b0, ramp_count};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    // ----------------------------------------
    // Phase accumulator
    // ----------------------------------------
    logic [ACC_W-1:0] acc;
    logic cont_clear;
    assign cont_clear = active.control[BIT_CONT_CLEAR];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= '0;
        end else if (cont_clear) begin
            acc <= '0;
        end else if (ce) begin
            if (update && shadow.control[BIT_AUTO_CLEAR]) begin
                acc <= '0;
            end else begin
                acc <= acc + active.tuning;
            end
        end
    end
    // ----------------------------------------
    // Dither source
    // ----------------------------------------
    logic [15:0] lfsr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr <= LFSR_SEED;
        end else if (ce) begin
            lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
        end
    end
    // ----------------------------------------
    // Phase word with offset and dither
    // ----------------------------------------
    logic [PHASE_OUT_W-1:0] phase_sum;
    logic [3:0] dither_en;
    logic [PHASE_OUT_W-1:0] dither_mask;
    assign dither_en = active.control[BIT_PH_DITHER_HI:BIT_PH_DITHER_LO];
    assign phase_sum = acc[ACC_W-1 -: PHASE_OUT_W]
        + PHASE_OUT_W'({active.phase, {(PHASE_OUT_W-PHASE_OFF_FRAC){1'b0}}});
    assign dither_mask = {{(PHASE_OUT_W-4){1'b0}}, dither_en};
    // ----------------------------------------
    // Keying mode and scale factor
    // ----------------------------------------
    ddsk_mode_type mode;
    ddsk_mode_type mode_prev;
    logic key_change;
    logic timer_reload;
    logic key_run;
    always_comb begin
        if (!active.control[BIT_KEY_ENABLE]) begin
            mode = ddsk_key_off_type_e;
        end else if (active.control[BIT_KEY_AUTO]) begin
            mode = ddsk_key_auto;
        end else begin
            mode = ddsk_key_manual;
        end
    end
    assign key_run = (mode == ddsk_key_auto);
    assign key_change = key_s2 ^ key_s3;
    assign timer_reload = key_change
        || (update && shadow.control[BIT_LOAD_TIMER])
        || (key_run && mode_prev != ddsk_key_auto);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_prev <= ddsk_key_off_type_e;
        end else if (ce) begin
            mode_prev <= mode;
        end
    end
    ddsk_ramp #(
        .RATE_W(8)
    ) u_ramp (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(key_run),
        .reload(timer_reload),
        .key_up(key_s2),
        .rate(active.ramp_rate),
        .step_sel(active.scale[STEP_SEL_HI:STEP_SEL_LO]),
        .ceiling(active.scale[SCALE_W-1:0]),
        .count(ramp_count)
    );
    // ----------------------------------------
    // Output register
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dds_out <= '0;
        end else if (ce) begin
            dds_out.phase_word <= phase_sum ^ (dither_mask & PHASE_OUT_W'(lfsr[3:0]));
            dds_out.scale_active <= (mode != ddsk_key_off_type_e);
            if (mode == ddsk_key_auto) begin
                dds_out.scale_factor <= ramp_count;
            end else if (mode == ddsk_key_manual) begin
                dds_out.scale_factor <= active.scale[SCALE_W-1:0];
            end else begin
                dds_out.scale_factor <= SCALE_FULL;
            end
            if (active.control[BIT_AMP_DITHER]) begin
                dds_out.amp_dither <= lfsr[15:14];
            end else begin
                dds_out.amp_dither <= '0;
            end
        end
    end
endmodule

/* File: core/ddsk_pkg.sv */
package ddsk_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_SCALE = 8'h04;
    localparam logic [7:0] ADDR_RAMP = 8'h08;
    localparam logic [7:0] ADDR_TUNING = 8'h0C;
    localparam logic [7:0] ADDR_PHASE = 8'h10;
    localparam logic [7:0] ADDR_UPDATE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // ----------------------------------------
    // Control word one bit positions
    // ----------------------------------------
    localparam int BIT_LOAD_TIMER = 26;
    localparam int BIT_KEY_ENABLE = 25;
    localparam int BIT_KEY_AUTO = 24;
    localparam int BIT_AMP_DITHER = 20;
    localparam int BIT_PH_DITHER_HI = 19;
    localparam int BIT_PH_DITHER_LO = 16;
    localparam int BIT_AUTO_CLEAR = 13;
    localparam int BIT_CONT_CLEAR = 10;
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h071F_2400;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // ----------------------------------------
    // Field layout and widths
    // ----------------------------------------
    localparam int SCALE_W = 14;
    localparam int STEP_SEL_HI = 15;
    localparam int STEP_SEL_LO = 14;
    localparam int PHASE_OFF_W = 10;
    localparam int PHASE_OFF_FRAC = 14;
    localparam int PHASE_DITHER_LO = 13;
    localparam int PHASE_OUT_W = 19;
    localparam int PHASE_OUT_LO = 13;
    localparam int AMP_DITHER_W = 2;
    localparam logic [SCALE_W-1:0] SCALE_FULL = 14'h3FFF;
    localparam logic [7:0] RATE_RELOAD_AT = 8'h01;
    localparam logic [1:0] QUARTER_DIV = 2'h3;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    // ----------------------------------------
    // Bus responses and types
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ddsk_key_off_type_e = 2'b00,
        ddsk_key_manual = 2'b01,
        ddsk_key_auto = 2'b11
    } ddsk_mode_type;
    typedef struct packed {
        logic [31:0] control;
        logic [15:0] scale;
        logic [7:0] ramp_rate;
        logic [31:0] tuning;
        logic [9:0] phase;
    } ddsk_regs_type;
    typedef struct packed {
        logic [PHASE_OUT_W-1:0] phase_word;
        logic [SCALE_W-1:0] scale_factor;
        logic scale_active;
        logic [AMP_DITHER_W-1:0] amp_dither;
    } ddsk_out_type;
endpackage

/* File: core/ddsk_ramp.sv */
module ddsk_ramp
    import ddsk_pkg::*;
#(
    parameter int RATE_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic run,
    input wire logic reload,
    input wire logic key_up,
    input wire logic [RATE_W-1:0] rate,
    input wire logic [1:0] step_sel,
    input wire logic [SCALE_W-1:0] ceiling,
    output logic [SCALE_W-1:0] count
);
    // ----------------------------------------
    // Rate down-counter
    // ----------------------------------------
    logic [RATE_W-1:0] timer;
    logic tick;
    logic [SCALE_W:0] step;
    logic [SCALE_W:0] next_up;
    assign tick = run && !reload && (timer <= RATE_W'(RATE_RELOAD_AT));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer <= '0;
        end else if (ce) begin
            if (reload || tick) begin
                timer <= rate;
            end else if (run) begin
                timer <= timer - 1'b1;
            end
        end
    end
    // ----------------------------------------
    // Scale counter
    // ----------------------------------------
    assign step = (SCALE_W+1)'(1) << step_sel;
    assign next_up = {1'b0, count} + step;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (ce && tick) begin
            if (key_up) begin
                if (next_up > {1'b0, ceiling}) begin
                    count <= (count > ceiling) ? count : ceiling;
                end else begin
                    count <= next_up[SCALE_W-1:0];
                end
            end else if ({1'b0, count} <= step) begin
                count <= '0;
            end else begin
                count <= count - step[SCALE_W-1:0];
            end
        end
    end
endmodule

/* File: testbench/ddsk_host.sv */
module ddsk_host
    import ddsk_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic quarter_rate_clock,
    input wire logic update_req,
    input wire logic key_level,
    input wire logic slow,
    output logic key_pin,
    output logic update_pin,
    output logic update_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic q_d;
    logic lag;
    logic [1:0] stage;
    // ------
    // Keying pin and update strobe
    // ------
    always_ff @(posedge aclk) begin
        q_d <= quarter_rate_clock;
        key_pin <= key_level;
        if (!aresetn) begin
            update_pin <= 1'h0;
            update_busy <= 1'h0;
            stage <= 2'h0;
            lag <= 1'h0;
        end else if (update_req && !update_busy) begin
            update_busy <= 1'h1;
            lag <= slow;
            stage <= 2'h0;
        end else if (update_busy && quarter_rate_clock && !q_d) begin
            if (lag) begin
                lag <= 1'h0;
            end else begin
                stage <= stage + 2'h1;
                update_pin <= stage == 2'h0;
                update_busy <= stage != 2'h2;
            end
        end
    end
endmodule

/* File: testbench/ddsk_sva.sv */
module ddsk_sva
    import ddsk_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic quarter_rate_clock,
    input wire ddsk_out_type dds_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Properties
    // ------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !ce);
    AST_QRATE_HIGH: assert property (
        $past(aresetn) && $rose(quarter_rate_clock)
        |=> quarter_rate_clock ##1 !quarter_rate_clock) else $error("quarter clock high wrong");
    AST_QRATE_LOW: assert property (
        $past(aresetn) && $fell(quarter_rate_clock)
        |=> !quarter_rate_clock ##1 quarter_rate_clock) else $error("quarter clock low wrong");
    AST_BYPASS_FULL: assert property (
        $past(aresetn) && $past(aresetn, 2) && !dds_out.scale_active
        |-> dds_out.scale_factor == SCALE_FULL) else $error("bypass scale wrong");
    AST_RESET_KEY_OFF: assert property (
        $rose(aresetn) |-> !dds_out.scale_active && dds_out.amp_dither == 2'h0)
        else $error("keying on after reset");
    AST_WRITE_ANSWER: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_READ_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_REFUSE: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
endmodule

bind ddsk_core ddsk_sva u_sva (
    .aclk, .aresetn, .ce, .quarter_rate_clock, .dds_out, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

/* File: testbench/tb_dds_phase_amplitude_keying.sv */
module tb_dds_phase_amplitude_keying
    import ddsk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic ce = 1'h1;
    logic key_level = 1'h0;
    logic update_req = 1'h0;
    logic slow = 1'h0;
    logic quarter_rate_clock, key_pin, update_pin, update_busy;
    ddsk_out_type dds_out;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int failures = 0;
    int comparisons = 0;
    int seed = 32'h83a8_b55e;
    logic [31:0] d, v, t;
    logic [7:0] adr [5] = '{ADDR_CONTROL, ADDR_SCALE, ADDR_RAMP, ADDR_TUNING, ADDR_PHASE};
    logic [31:0] msk [5] = '{CONTROL_WRITE_MASK, 32'h0000_FFFF, 32'h0000_00FF, 32'hFFFF_FFFF,
        32'h0000_03FF};
    ddsk_core #(.ACC_W(32)) DUT (
        .aclk, .aresetn, .ce, .key_pin, .update_pin, .quarter_rate_clock, .dds_out,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    ddsk_host host (
        .aclk, .aresetn, .quarter_rate_clock, .update_req, .key_level, .slow, .key_pin,
        .update_pin, .update_busy
    );
    initial begin
        forever #5 aclk = ~aclk;
    end
    // ------
    // Checking and bus tasks
    // ------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        comparisons++;
        if (seen !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic wrap_up;
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dat,
            output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        int lag;
        logic ha, hw, hr;
        lag = $random(seed) & 3;
        hr = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        for (n = 0; n < 60 && !hr; n++) begin
            s_axi_bready <= wr && n >= lag;
            s_axi_rready <= !wr && n >= lag;
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
            hw = s_axi_wvalid && s_axi_wready;
            hr = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ha && wr) s_axi_awvalid <= 1'h0;
            if (ha && !wr) s_axi_arvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        if (!hr) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat,
            input logic [1:0] e = RESP_OKAY);
        logic [31:0] rd;
        logic [1:0] rsp;
        xfer(1'h1, a, dat, rd, rsp);
        chk("bresp", 32'(rsp), 32'(e));
    endtask
    task automatic upd;
        int n;
        slow <= 1'($random(seed));
        update_req <= 1'h1;
        @(posedge aclk);
        update_req <= 1'h0;
        for (n = 0; n < 200; n++) begin
            @(negedge aclk);
            if (!update_busy) break;
        end
        if (update_busy !== 1'h0) begin
            failures++;
            wrap_up();
        end
        repeat (6) @(posedge aclk);
    endtask
    task automatic cfg(input logic [31:0] c, s, a, tw, p);
        wr_reg(ADDR_CONTROL, c);
        wr_reg(ADDR_SCALE, s);
        wr_reg(ADDR_RAMP, a);
        wr_reg(ADDR_TUNING, tw);
        wr_reg(ADDR_PHASE, p);
        upd();
    endtask
    task automatic step_is(input logic [18:0] e);
        logic [18:0] p, dl;
        @(negedge aclk);
        p = dds_out.phase_word;
        @(negedge aclk);
        dl = dds_out.phase_word - p;
        chk("phase_step", 32'(dl), 32'(e));
        @(posedge aclk);
    endtask
    function automatic logic [13:0] next_scale(input logic up, input logic [13:0] p, st, c);
        if (up) return (c - p < st) ? c : p + st;
        return (p < st) ? 14'h0 : p - st;
    endfunction
    task automatic ramp(input logic up, input logic [13:0] st, input logic [13:0] c,
            input int rt);
        logic [13:0] prv, e, fin;
        int n;
        int gap;
        gap = -9999;
        fin = up ? c : 14'h0;
        key_level <= up;
        @(negedge aclk);
        prv = dds_out.scale_factor;
        for (n = 0; n < 3000 && prv !== fin; n++) begin
            @(negedge aclk);
            gap++;
            if (dds_out.scale_factor !== prv) begin
                e = next_scale(up, prv, st, c);
                chk("ramp_step", 32'(dds_out.scale_factor), 32'(e));
                if (gap > 0) chk("ramp_period", 32'(gap), 32'(rt));
                gap = 0;
                prv = dds_out.scale_factor;
            end
        end
        chk("ramp_end", 32'(prv), 32'(fin));
        @(posedge aclk);
    endtask
    // ------
    // Main sequence
    // ------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(negedge aclk);
        chk("key_active", 32'(dds_out.scale_active), 32'h0);
        chk("bypass_scale", 32'(dds_out.scale_factor), 32'(SCALE_FULL));
        chk("amp_dither_off", 32'(dds_out.amp_dither), 32'h0);
        xfer(1'h0, ADDR_CONTROL, 32'h0, d, r);
        chk("control_reset", d, CONTROL_RESET);
        xfer(1'h0, 8'h1C, 32'h0, d, r);
        chk("unmapped_rresp", 32'(r), 32'(RESP_SLVERR));
        chk("unmapped_rdata", d, 32'h0);
        wr_reg(8'h1C, 32'h0000_0001, RESP_SLVERR);
        for (int i = 0; i < 20; i++) begin
            v = $random(seed);
            wr_reg(adr[i % 5], v);
            xfer(1'h0, adr[i % 5], 32'h0, d, r);
            chk("reg_readback", d, v & msk[i % 5]);
        end
        v = $random(seed) & 32'h0000_03FF;
        cfg(32'h1 << BIT_CONT_CLEAR, 32'h0, 32'h1, $random(seed), v);
        repeat (4) begin
            @(negedge aclk);
            chk("cleared_phase", 32'(dds_out.phase_word), {17'h0, v[9:0], 5'h0});
        end
        t = $random(seed) & 32'hFFFF_E000;
        cfg(32'h0, 32'h0, 32'h1, t, 32'h0);
        step_is(t[31:13]);
        v = $random(seed) & 32'hFFFF_E000;
        wr_reg(ADDR_TUNING, v);
        step_is(t[31:13]);
        upd();
        step_is(v[31:13]);
        cfg(32'h1 << BIT_AUTO_CLEAR, 32'h0, 32'h1, 32'h0002_0000, 32'h0);
        repeat (2) begin
            @(negedge aclk);
            chk("auto_clear", 32'(dds_out.phase_word < 19'h0_0100), 32'h1);
            upd();
        end
        ce <= 1'h0;
        @(negedge aclk);
        d = 32'(dds_out.phase_word);
        repeat (3) @(negedge aclk);
        chk("ce_freeze", 32'(dds_out.phase_word), d);
        @(posedge aclk);
        ce <= 1'h1;
        for (int i = 0; i <= 4; i++) begin
            cfg((32'h1 << BIT_CONT_CLEAR) | (32'h1 << (BIT_PH_DITHER_LO + i)), 32'h0, 32'h1,
                32'h0, 32'h0);
            v = 32'h0;
            t = 32'h0;
            repeat (64) begin
                @(negedge aclk);
                v = v | 32'(dds_out.phase_word);
                t = t | 32'(dds_out.amp_dither);
            end
            chk("phase_dither", v, i < 4 ? 32'h1 << i : 32'h0);
            chk("amp_dither", 32'(t != 32'h0), 32'(i == 4));
        end
        for (int i = 0; i < 3; i++) begin
            v = i == 0 ? 32'h0000_FFFF : i == 1 ? 32'h0000_C000 : $random(seed);
            cfg(32'h1 << BIT_KEY_ENABLE, v, 32'h1, 32'h0, 32'h0);
            @(negedge aclk);
            chk("manual_active", 32'(dds_out.scale_active), 32'h1);
            chk("manual_scale", 32'(dds_out.scale_factor), 32'(v[13:0]));
        end
        for (int i = 0; i < 4; i++) begin
            v = 32'h0000_0101 + 32'(2 * i);
            t = 32'h1 + ($random(seed) & 32'h3);
            cfg((32'h1 << BIT_KEY_ENABLE) | (32'h1 << BIT_KEY_AUTO), v | (32'(i) << 14), t,
                32'h0, 32'h0);
            ramp(1'h1, 14'h1 << i, v[13:0], t);
            ramp(1'h0, 14'h1 << i, v[13:0], t);
        end
        wrap_up();
    end
endmodule
